// file: sfr_bank_pkg.sv
// Constants and the behaviour list of the core special register bank.
// Behaviour
// R1 - Top 128 addresses, direct access only
// R2 - All core registers live in this space
// R3 - Status word at 0xD0, bit addressable
// R4 - Data pointer is high byte over low
// R5 - Carry and overflow set by arithmetic ops
// R6 - Half carry set only by add ops
// R7 - Bits five and one are user flags
// R8 - Bits four and three pick register bank
// R9 - Bit zero keeps operand parity even
// R10 - Power bit seven doubles baud, resets zero
// R11 - Software keeps power bits six-zero zero
// R12 - Data pointer low resets to zero
// R13 - Data pointer high resets to zero
// R14 - Stack high 0xB7, limit 0xBF, byte only
// R15 - Configuration at 0xAF, byte only
// R16 - Writes visible from next instruction
`default_nettype none
package sfr_bank_pkg;
  // Register addresses.
  localparam logic [7:0] SFR_BASE   = 8'h80;
  localparam logic [7:0] ADDR_SP    = 8'h81;
  localparam logic [7:0] ADDR_DPL   = 8'h82;
  localparam logic [7:0] ADDR_DPH   = 8'h83;
  localparam logic [7:0] ADDR_POWER_CONTROL_WORD  = 8'h87;
  localparam logic [7:0] ADDR_CFG   = 8'hAF;
  localparam logic [7:0] ADDR_SPH   = 8'hB7;
  localparam logic [7:0] ADDR_STACK_LIMIT_CONTROL = 8'hBF;
  localparam logic [7:0] ADDR_PSW   = 8'hD0;
  localparam logic [7:0] ADDR_ACC   = 8'hE0;
  localparam logic [7:0] ADDR_B     = 8'hF0;
  // Status word field positions.
  localparam int PSW_CY  = 7;
  localparam int PSW_AC  = 6;
  localparam int PSW_F0  = 5;
  localparam int PSW_RSH = 4;
  localparam int PSW_RSL = 3;
  localparam int PSW_OV  = 2;
  localparam int PSW_F1  = 1;
  localparam int PSW_P   = 0;
  localparam int POWER_CONTROL_WORD_BAUD = 7;
  // Reset values.
  localparam logic [7:0] RST_ZERO  = 8'h00;
  localparam logic [7:0] RST_SP    = 8'h07;
  localparam logic [7:0] RST_SPH   = 8'h89;
  localparam logic [7:0] RST_CFG   = 8'h81;
  localparam logic [7:0] POWER_CONTROL_WORD_MASK = 8'h80;
  localparam logic [7:0] UNMAPPED  = 8'h00;
  // Arithmetic operation classes reported by the datapath.
  typedef enum logic [2:0] {OP_NONE, OP_ADD, OP_ADDC, OP_SUBB, OP_MUL, OP_DIV} alu_op_t;
endpackage
`default_nettype wire

// file: sfr_bit_merge.sv
// Read-modify-write helper for single-bit accesses to a register byte.
`timescale 1ns/1ns
`default_nettype none
module sfr_bit_merge
  import sfr_bank_pkg::*;
(
  // Byte being modified.
  input  wire logic [7:0] old_i,
  // Bit select and value.
  input  wire logic [2:0] bit_sel_i,
  input  wire logic       bit_val_i,
  // Merged byte.
  output logic      [7:0] new_o
);
  // Replace only the selected bit; the other seven are kept.
  always_comb begin
    new_o            = old_i;
    new_o[bit_sel_i] = bit_val_i;
  end
endmodule // sfr_bit_merge
`default_nettype wire

// file: sfr_bank.sv
// Core special register bank: direct-address decode, status word and pointers.
`timescale 1ns/1ns
`default_nettype none
module sfr_bank
  import sfr_bank_pkg::*;
(
  // Clock and reset.
  input  wire logic       mclk_i,
  input  wire logic       resetn_i,
  // Direct-address access from the core.
  input  wire logic [7:0] addr_i,
  input  wire logic       direct_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire logic       bit_op_i,
  input  wire logic [2:0] bit_sel_i,
  input  wire logic       bit_val_i,
  input  wire logic [7:0] wdata_i,
  // Flag updates from the arithmetic unit.
  input  wire alu_op_t    alu_op_i,
  input  wire logic       alu_cy_i,
  input  wire logic       alu_ac_i,
  input  wire logic       alu_ov_i,
  // Result write to the operand register.
  input  wire logic       acc_we_i,
  input  wire logic [7:0] acc_d_i,
  // Read data.
  output logic      [7:0] rdata_o,
  output logic            hit_o,
  // Register contents toward the datapath.
  output logic      [7:0] main_operand_register_o,
  output logic      [7:0] aux_multiply_operand_o,
  output logic      [7:0] program_status_word_o,
  output logic     [15:0] data_pointer_pair_o,
  output logic      [7:0] stack_pointer_o,
  output logic      [7:0] stack_pointer_high_o,
  output logic      [7:0] stack_limit_control_o,
  output logic      [7:0] core_configuration_o,
  output logic      [1:0] bank_select_o,
  output logic            baud_doubler_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Storage.
  logic [7:0] acc_r;   // Main operand register.
  logic [7:0] b_r;     // Auxiliary multiply operand.
  logic [7:0] psw_r;   // Status word bits 7..1; bit 0 is computed.
  logic [7:0] power_control_word_r;  // Power control word.
  logic [7:0] dpl_r;   // Pointer low byte.
  logic [7:0] dph_r;   // Pointer high byte.
  logic [7:0] sp_r;    // Stack pointer.
  logic [7:0] sph_r;   // Stack pointer high.
  logic [7:0] stc_r;   // Stack limit control.
  logic [7:0] cfg_r;   // Core configuration.

  ////////////////////////////////////////////////////////////////////////////
  // Decode. Indirect accesses go to RAM, never here.
  wire in_space  = direct_i && (addr_i >= SFR_BASE);  // R1
  wire wr_ok     = in_space && wr_i;                  // R1
  wire sel_acc   = addr_i == ADDR_ACC;
  wire sel_b     = addr_i == ADDR_B;
  wire sel_psw   = addr_i == ADDR_PSW;
  wire sel_power_control_word  = addr_i == ADDR_POWER_CONTROL_WORD;
  wire sel_dpl   = addr_i == ADDR_DPL;
  wire sel_dph   = addr_i == ADDR_DPH;
  wire sel_sp    = addr_i == ADDR_SP;
  wire sel_sph   = addr_i == ADDR_SPH;
  wire sel_stc   = addr_i == ADDR_STACK_LIMIT_CONTROL;
  wire sel_cfg   = addr_i == ADDR_CFG;
  // Only the two operand registers and the status word take bit accesses.
  wire bit_able  = sel_acc || sel_b || sel_psw;                     // R3 R14 R15
  wire byte_wr   = wr_ok && !bit_op_i;
  wire bit_wr    = wr_ok && bit_op_i && bit_able;                  // R3
  wire mapped    = sel_acc | sel_b | sel_psw | sel_power_control_word | sel_dpl | sel_dph
                 | sel_sp | sel_sph | sel_stc | sel_cfg;           // R2

  // Parity is even over operand plus this bit.
  wire parity    = ^acc_r;                                         // R9
  wire [7:0] psw_view = {psw_r[7:1], parity};

  // Selected current value, for reads and bit merges.
  wire [7:0] cur =
      sel_acc  ? acc_r  : sel_b   ? b_r   : sel_psw ? psw_view :
      sel_power_control_word ? power_control_word_r : sel_dpl ? dpl_r : sel_dph ? dph_r :
      sel_sp   ? sp_r   : sel_sph ? sph_r : sel_stc ? stc_r :
      sel_cfg  ? cfg_r  : UNMAPPED;

  wire [7:0] merged;
  // Single-bit write data built from the current byte.
  sfr_bit_merge u_merge (
    .old_i     (cur),
    .bit_sel_i (bit_sel_i),
    .bit_val_i (bit_val_i),
    .new_o     (merged)
  );
  wire [7:0] wval = bit_op_i ? merged : wdata_i;
  wire do_wr = byte_wr || bit_wr;

  // Flag update classes from the arithmetic unit.
  wire op_cy_ov = (alu_op_i == OP_ADD) || (alu_op_i == OP_ADDC) || (alu_op_i == OP_SUBB)
               || (alu_op_i == OP_MUL) || (alu_op_i == OP_DIV);              // R5
  wire op_ac    = (alu_op_i == OP_ADD) || (alu_op_i == OP_ADDC);             // R6

  // Next status word: software write first, then arithmetic flags win.
  logic [7:0] psw_nxt;
  always_comb begin
    psw_nxt = psw_r;
    if (do_wr && sel_psw) begin
      psw_nxt = wval;                                       // R7 R8
    end
    if (op_cy_ov) begin
      psw_nxt[PSW_CY] = alu_cy_i;                           // R5
      psw_nxt[PSW_OV] = alu_ov_i;                           // R5
    end
    if (op_ac) begin
      psw_nxt[PSW_AC] = alu_ac_i;                           // R6
    end
    psw_nxt[PSW_P] = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status word and operand registers.
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      psw_r <= RST_ZERO;
      acc_r <= RST_ZERO;
      b_r   <= RST_ZERO;
    end else begin
      psw_r <= psw_nxt;                                     // R16
      if (do_wr && sel_acc) begin
        acc_r <= wval;
      end else if (acc_we_i) begin
        acc_r <= acc_d_i;
      end
      if (do_wr && sel_b) begin
        b_r <= wval;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte-only registers.
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      power_control_word_r <= RST_ZERO;                                   // R10
      dpl_r  <= RST_ZERO;                                   // R12
      dph_r  <= RST_ZERO;                                   // R13
      sp_r   <= RST_SP;
      sph_r  <= RST_SPH;
      stc_r  <= RST_ZERO;
      cfg_r  <= RST_CFG;
    end else if (byte_wr) begin
      // Reserved power bits are held at zero whatever is written.
      if (sel_power_control_word) power_control_word_r <= wdata_i & POWER_CONTROL_WORD_MASK;          // R10 R11
      if (sel_dpl)  dpl_r  <= wdata_i;                      // R4 R12
      if (sel_dph)  dph_r  <= wdata_i;                      // R4 R13
      if (sel_sp)   sp_r   <= wdata_i;
      if (sel_sph)  sph_r  <= wdata_i;                      // R14
      if (sel_stc)  stc_r  <= wdata_i;                      // R14
      if (sel_cfg)  cfg_r  <= wdata_i;                      // R15
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs, one cycle behind storage.
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      rdata_o <= UNMAPPED;
      hit_o   <= 1'b0;
    end else begin
      rdata_o <= (in_space && rd_i) ? cur : UNMAPPED;      // R1
      hit_o   <= in_space && rd_i && mapped;
    end
  end

  // Datapath views; these track storage directly through flops.
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      main_operand_register_o <= RST_ZERO;
      aux_multiply_operand_o  <= RST_ZERO;
      program_status_word_o   <= RST_ZERO;
      data_pointer_pair_o     <= {RST_ZERO, RST_ZERO};
      stack_pointer_o         <= RST_SP;
      stack_pointer_high_o    <= RST_SPH;
      stack_limit_control_o   <= RST_ZERO;
      core_configuration_o    <= RST_CFG;
      bank_select_o           <= 2'h0;
      baud_doubler_o          <= 1'b0;
    end else begin
      main_operand_register_o <= acc_r;
      aux_multiply_operand_o  <= b_r;
      program_status_word_o   <= psw_view;                 // R9
      data_pointer_pair_o     <= {dph_r, dpl_r};           // R4
      stack_pointer_o         <= sp_r;
      stack_pointer_high_o    <= sph_r;
      stack_limit_control_o   <= stc_r;
      core_configuration_o    <= cfg_r;
      bank_select_o           <= psw_r[PSW_RSH:PSW_RSL];   // R8
      baud_doubler_o          <= power_control_word_r[POWER_CONTROL_WORD_BAUD];        // R10
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  property p_indirect_ignored;
    @(posedge mclk_i) disable iff (!resetn_i)
    (!direct_i && wr_i && !acc_we_i) |=> $stable(acc_r) && $stable(dpl_r);
  endproperty
  a_indirect_ignored: assert property (p_indirect_ignored) else $error("indirect write reached bank"); // R1

  property p_psw_write;
    @(posedge mclk_i) disable iff (!resetn_i)
    (byte_wr && sel_psw && alu_op_i == OP_NONE) |=> psw_r[7:1] == $past(wdata_i[7:1]);
  endproperty
  a_psw_write: assert property (p_psw_write) else $error("status byte write lost"); // R3

  property p_data_pointer_pair_pair;
    @(posedge mclk_i) disable iff (!resetn_i)
    1'b1 |=> data_pointer_pair_o == $past({dph_r, dpl_r});
  endproperty
  a_data_pointer_pair_pair: assert property (p_data_pointer_pair_pair) else $error("pointer pair mismatch"); // R4

  property p_cy_update;
    @(posedge mclk_i) disable iff (!resetn_i)
    op_cy_ov |=> psw_r[PSW_CY] == $past(alu_cy_i) && psw_r[PSW_OV] == $past(alu_ov_i);
  endproperty
  a_cy_update: assert property (p_cy_update) else $error("carry or overflow not updated"); // R5

  property p_ac_only_add;
    @(posedge mclk_i) disable iff (!resetn_i)
    (!op_ac && !(do_wr && sel_psw)) |=> $stable(psw_r[PSW_AC]);
  endproperty
  a_ac_only_add: assert property (p_ac_only_add) else $error("half carry changed"); // R6

  property p_user_flags;
    @(posedge mclk_i) disable iff (!resetn_i)
    !(do_wr && sel_psw) |=> $stable(psw_r[PSW_F0]) && $stable(psw_r[PSW_F1]) && $stable(psw_r[4:3]);
  endproperty
  a_user_flags: assert property (p_user_flags) else $error("user flag changed"); // R7

  // The published parity bit together with the operand bits it covers must
  // always count even. The other status bits are left out of the sum on purpose,
  // because user flags and bank bits would otherwise make it fail.
  property p_parity;
    @(posedge mclk_i) disable iff (!resetn_i)
    1'b1 |=> (program_status_word_o[PSW_P] ^ (^$past(acc_r))) == 1'b0;
  endproperty
  a_parity: assert property (p_parity) else $error("parity not even"); // R9

  property p_power_control_word_reserved;
    @(posedge mclk_i) disable iff (!resetn_i)
    1'b1 |-> power_control_word_r[6:0] == 7'h00;
  endproperty
  a_power_control_word_reserved: assert property (p_power_control_word_reserved) else $error("power reserved bits set"); // R11

  property p_no_bit_sph;
    @(posedge mclk_i) disable iff (!resetn_i)
    (wr_ok && bit_op_i && (sel_sph || sel_stc || sel_cfg || sel_dpl)) |=> $stable(sph_r) && $stable(stc_r)
      && $stable(cfg_r) && $stable(dpl_r);
  endproperty
  a_no_bit_sph: assert property (p_no_bit_sph) else $error("bit write to byte register"); // R14

  // The bank select view follows the stored select bits one edge later.
  property p_bank_view;
    @(posedge mclk_i) disable iff (!resetn_i)
    1'b1 |=> bank_select_o == $past(psw_r[PSW_RSH:PSW_RSL]);
  endproperty
  a_bank_view: assert property (p_bank_view) else $error("bank select view wrong"); // R8

  // The baud doubler view follows the stored power bit one edge later.
  property p_baud_view;
    @(posedge mclk_i) disable iff (!resetn_i)
    1'b1 |=> baud_doubler_o == $past(power_control_word_r[POWER_CONTROL_WORD_BAUD]);
  endproperty
  a_baud_view: assert property (p_baud_view) else $error("baud doubler view wrong"); // R10

  // A read below the register space is a memory read and must not hit here.
  property p_low_read_miss;
    @(posedge mclk_i) disable iff (!resetn_i)
    (direct_i && rd_i && (addr_i < SFR_BASE)) |=> !hit_o && rdata_o == UNMAPPED;
  endproperty
  a_low_read_miss: assert property (p_low_read_miss) else $error("low address read hit the bank"); // R1

  // Without a read strobe the read port rests at zero, so stale data never leaks.
  property p_rdata_idle;
    @(posedge mclk_i) disable iff (!resetn_i)
    !rd_i |=> !hit_o && rdata_o == UNMAPPED;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read port not idle"); // R1

  // A bus write to the operand register beats a same-cycle result write.
  // Software expects its own store to be what the next instruction sees.
  property p_bus_beats_result;
    @(posedge mclk_i) disable iff (!resetn_i)
    (do_wr && sel_acc && acc_we_i) |=> acc_r == $past(wval);
  endproperty
  a_bus_beats_result: assert property (p_bus_beats_result) else $error("operand store lost"); // R16

  // A byte write to the pointer high byte lands in storage on the next edge.
  property p_pointer_high_write;
    @(posedge mclk_i) disable iff (!resetn_i)
    (byte_wr && sel_dph) |=> dph_r == $past(wdata_i);
  endproperty
  a_pointer_high_write: assert property (p_pointer_high_write) else $error("pointer high write lost"); // R13
endmodule // sfr_bank
`default_nettype wire

// file: sfr_bank_bench.sv
// Self-checking random bench for the core special register bank.
`timescale 1ns/1ns
`default_nettype none
module sfr_bank_bench;
  import sfr_bank_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  // Design inputs, named as the ports so they connect by name.
  logic        mclk_i, resetn_i, direct_i, wr_i, rd_i, bit_op_i, bit_val_i;
  logic        alu_cy_i, alu_ac_i, alu_ov_i, acc_we_i;
  logic [7:0]  addr_i, wdata_i, acc_d_i;
  logic [2:0]  bit_sel_i;
  alu_op_t     alu_op_i;
  // Design outputs.
  logic [7:0]  rdata_o, main_operand_register_o, aux_multiply_operand_o, program_status_word_o;
  logic [7:0]  stack_pointer_o, stack_pointer_high_o, stack_limit_control_o, core_configuration_o;
  logic [15:0] data_pointer_pair_o;
  logic [1:0]  bank_select_o;
  logic        hit_o, baud_doubler_o;
  // Reference image of every register, and the map of decoded addresses.
  logic [7:0]  m [256];
  logic [7:0]  regs [10] = '{ADDR_SP, ADDR_DPL, ADDR_DPH, ADDR_POWER_CONTROL_WORD, ADDR_CFG,
                             ADDR_SPH, ADDR_STACK_LIMIT_CONTROL, ADDR_PSW, ADDR_ACC, ADDR_B};
  logic [7:0]  a, d;
  logic [2:0]  s;
  int          n_errors, n_tests;
  ////////////////////////////////////////////////////////////////////////
  sfr_bank DUT (.mclk_i, .resetn_i, .addr_i, .direct_i, .wr_i, .rd_i, .bit_op_i, .bit_sel_i,
    .bit_val_i, .wdata_i, .alu_op_i, .alu_cy_i, .alu_ac_i, .alu_ov_i, .acc_we_i, .acc_d_i,
    .rdata_o, .hit_o, .main_operand_register_o, .aux_multiply_operand_o, .program_status_word_o,
    .data_pointer_pair_o, .stack_pointer_o, .stack_pointer_high_o, .stack_limit_control_o,
    .core_configuration_o, .bank_select_o, .baud_doubler_o);
  ////////////////////////////////////////////////////////////////////////
  // True when the address is one of the decoded registers.
  function automatic logic mapped(input logic [7:0] x);
    mapped = 1'b0;
    foreach (regs[i]) if (regs[i] == x) mapped = 1'b1;
  endfunction
  // Expected byte; the status word carries live parity of the operand register.
  function automatic logic [7:0] exp_rd(input logic [7:0] x);
    exp_rd = (x == ADDR_PSW) ? {m[x][7:1], ^m[ADDR_ACC]} : m[x];
  endfunction
  // One comparison; unknowns never match.
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One bus cycle: request held for one edge, then strobes dropped.
  task automatic access(input logic [7:0] x, input logic dir, w, r, bo, input logic [2:0] bs,
                        input logic [7:0] wd);
    @(posedge mclk_i);
    addr_i <= x;
    direct_i <= dir;
    wr_i <= w;
    rd_i <= r;
    bit_op_i <= bo;
    bit_sel_i <= bs;
    bit_val_i <= wd[0];
    wdata_i <= wd;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    bit_op_i <= 1'b0;
    @(negedge mclk_i);
  endtask
  // Read and compare; indirect or unmapped reads must return zero without a hit.
  task automatic rdchk(input logic [7:0] x, input logic dir);
    access(x, dir, 1'b0, 1'b1, 1'b0, 3'h0, 8'h00);
    chk("rdata", rdata_o, (dir && mapped(x)) ? exp_rd(x) : 8'h00);
    chk("hit", hit_o, dir && mapped(x));
  endtask
  // Views lag storage by one edge, so let one more edge pass first.
  task automatic views();
    @(posedge mclk_i);
    @(negedge mclk_i);
    chk("data_pointer_pair", data_pointer_pair_o, {m[ADDR_DPH], m[ADDR_DPL]});
    chk("psw", program_status_word_o, exp_rd(ADDR_PSW));
    chk("bank", bank_select_o, m[ADDR_PSW][4:3]);
    chk("baud", baud_doubler_o, m[ADDR_POWER_CONTROL_WORD][7]);
    chk("sph", stack_pointer_high_o, m[ADDR_SPH]);
    chk("stack_limit_control", stack_limit_control_o, m[ADDR_STACK_LIMIT_CONTROL]);
    chk("cfg", core_configuration_o, m[ADDR_CFG]);
    chk("acc", main_operand_register_o, m[ADDR_ACC]);
    chk("b", aux_multiply_operand_o, m[ADDR_B]);
    chk("sp", stack_pointer_o, m[ADDR_SP]);
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // 25 MHz clock.
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  // Watchdog sized well above the expected run of about six hundred cycles.
  initial begin
    repeat (20000) @(posedge mclk_i);
    n_errors++;
    final_report();
  end
  // Main sequence.
  initial begin
    {resetn_i, direct_i, wr_i, rd_i, bit_op_i, bit_val_i, alu_cy_i, alu_ac_i, alu_ov_i, acc_we_i} = '0;
    {addr_i, wdata_i, acc_d_i, bit_sel_i} = '0;
    alu_op_i = OP_NONE;
    n_errors = 0;
    n_tests = 0;
    void'($urandom(32'hF440));
    foreach (m[i]) m[i] = 8'h00;
    m[ADDR_SP] = RST_SP;
    m[ADDR_SPH] = RST_SPH;
    m[ADDR_CFG] = RST_CFG;
    repeat (12) @(posedge mclk_i);
    resetn_i <= 1'b1;
    // Reset values of every register, then the views.
    foreach (regs[i]) rdchk(regs[i], 1'b1);
    views();
    // Random byte writes, each read back on the very next access.
    repeat (4) foreach (regs[i]) begin
      d = $urandom;
      access(regs[i], 1'b1, 1'b1, 1'b0, 1'b0, 3'h0, d);
      m[regs[i]] = (regs[i] == ADDR_POWER_CONTROL_WORD) ? (d & POWER_CONTROL_WORD_MASK) : d;
      rdchk(regs[i], 1'b1);
      views();
    end
    // Indirect writes and lower-half writes must leave the bank alone.
    repeat (10) begin
      a = regs[$urandom % 10];
      d = $urandom;
      access(a, 1'b0, 1'b1, 1'b0, 1'b0, 3'h0, d);
      access(a & 8'h7F, 1'b1, 1'b1, 1'b0, 1'b0, 3'h0, ~d);
      rdchk(a, 1'b0);
      rdchk(a, 1'b1);
      d = $urandom;
      rdchk(d | 8'h80, 1'b1);
    end
    // Single-bit writes only reach the bit-addressable registers.
    repeat (40) begin
      a = regs[$urandom % 10];
      s = $urandom;
      d = $urandom;
      access(a, 1'b1, 1'b1, 1'b0, 1'b1, s, d);
      if (a inside {ADDR_PSW, ADDR_ACC, ADDR_B}) m[a][s] = d[0];
      rdchk(a, 1'b1);
    end
    // Every operation class, with flags opposite to the stored ones.
    repeat (2) for (int k = 0; k < 6; k++) begin
      @(posedge mclk_i);
      alu_op_i <= alu_op_t'(k);
      alu_cy_i <= ~m[ADDR_PSW][7];
      alu_ac_i <= ~m[ADDR_PSW][6];
      alu_ov_i <= ~m[ADDR_PSW][2];
      @(posedge mclk_i);
      alu_op_i <= OP_NONE;
      if (k != 0) m[ADDR_PSW][7] = ~m[ADDR_PSW][7];
      if (k != 0) m[ADDR_PSW][2] = ~m[ADDR_PSW][2];
      if (k == 1 || k == 2) m[ADDR_PSW][6] = ~m[ADDR_PSW][6];
      rdchk(ADDR_PSW, 1'b1);
    end
    // Result writes to the operand register drive the parity bit.
    repeat (20) begin
      d = $urandom;
      @(posedge mclk_i);
      acc_we_i <= 1'b1;
      acc_d_i <= d;
      @(posedge mclk_i);
      acc_we_i <= 1'b0;
      m[ADDR_ACC] = d;
      views();
    end
    final_report();
  end
endmodule  // sfr_bank_bench
`default_nettype wire
